// ==== ftcu_timer.sv ====
// How it works
// RULE1: sixteen-bit up-counter advances on selected tick
// RULE2: rollover to zero sets the overflow flag
// RULE3: counter zero on reset, standby, match-A clear
// RULE4: counter bytes pass through shared holding latch
// RULE5: compare equality sets that channel's flag
// RULE6: enabled match drives pin to level bit
// RULE7: one address, select bit picks compare channel
// RULE8: compare registers reset to all ones
// RULE9: selected edge captures count and sets flag
// RULE10: capture happens even with flag set
// RULE11: buffer A shifts old A into C
// RULE12: buffer B shifts old B into D
// RULE13: buffered edge bits pick both or one edge
// RULE14: unbuffered channels use own edge bit
// RULE15: capture byte reads go through latch
// RULE16: source holds pulses 1.5 or 2.5 clocks
// RULE17: capture registers reset to zero
// RULE18: enables reset cleared, bit zero reads one
// RULE19: enable bits gate flags onto requests
// RULE20: buffered C/D edges only set flags
// RULE21: flags cleared by read-one then write-zero
// RULE22: flag register bit zero enables match-A clear
// RULE23: high byte first, low byte commits
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ftcu_params.svh"

module ftcu_timer
   import ftcu_pkg::*;
#(
   parameter int CNT_W = 16 // counter width
)
(
   input wire logic clock, // system clock, 50 MHz
   input wire logic nrst, // sync reset, low
   input wire logic standby, // standby mode, high
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic [2:0] hsize, // size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic [31:0] hrdata, // read data
   output logic hresp, // response
   input wire logic capture_pin_a, // capture input
   input wire logic capture_pin_b, // capture input
   input wire logic capture_pin_c, // capture input
   input wire logic capture_pin_d, // capture input
   input wire logic external_count_clock, // external count
   output logic compare_pin_a, // compare output
   output logic compare_pin_b, // compare output
   output logic [6:0] irq_request // cap a-d, cmp a-b, wrap
);
   if (CNT_W != 16)
   begin : g_chk
      $error("ftcu_timer: CNT_W must be 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic clr;
   logic [4:0] rise;
   logic [4:0] fall;
   logic tick;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] cmp_a;
   logic [CNT_W-1:0] cmp_b;
   logic [CNT_W-1:0] capv [4];
   logic [7:0] temp;
   logic [7:1] ien;
   logic [7:1] flags;
   logic [7:1] next_flags;
   logic [7:1] armed;
   logic [7:1] set_ev;
   logic cclr;
   ftcu_ctl_t ctl;
   ftcu_occ_t occ;
   ftcu_req_t req;
   logic [3:0] es;
   logic [1:0] bufe;
   logic [3:0] trig;
   logic match_a;
   logic match_b;
   logic wrap_ev;
   logic take;
   logic rok;
   logic rd;
   logic rbyte;
   logic [1:0] rlane;
   logic [15:0] ridx;
   logic [15:0] rv;
   logic rtemp;
   logic wr;
   logic commit;
   logic wr_hi;
   logic [15:0] wv16;
   logic [7:0] wv8;
   logic wr_cnt;
   logic flg_wr;
   logic flg_rd;

   assign clr = standby;
   assign es = {ctl.edge_select_d, ctl.edge_select_c, ctl.edge_select_b, ctl.edge_select_a};
   assign bufe = {ctl.buffer_enable_b, ctl.buffer_enable_a};

   ////////////////////////////////////////////////////////////////////////////
   // pin conditioning: 0-3 capture a-d, 4 external count clock
   for (genvar g = 0; g < 5; g++)
   begin : g_pin
      logic raw;
      if (g == 0)
      begin : g_a
         assign raw = capture_pin_a;
      end
      else if (g == 1)
      begin : g_b
         assign raw = capture_pin_b;
      end
      else if (g == 2)
      begin : g_c
         assign raw = capture_pin_c;
      end
      else if (g == 3)
      begin : g_d
         assign raw = capture_pin_d;
      end
      else
      begin : g_e
         assign raw = external_count_clock;
      end
      ftcu_sync u_sync
      (
         .clock(clock),
         .nrst(nrst),
         .pin(raw),
         .rise(rise[g]),
         .fall(fall[g])
      );
   end

   ftcu_presc u_presc
   (
      .clock(clock),
      .nrst(nrst),
      .clear(clr),
      .clock_select(ctl.clock_select),
      .ext_rise(rise[4]),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign take = hsel && hready && htrans[1];
   assign rok = haddr[31:18] == 14'h0000;
   assign rd = take && !hwrite && rok;
   assign ridx = haddr[17:2];
   assign rlane = haddr[1:0];
   assign rbyte = hsize == 3'h0;

   always_ff @(posedge clock)
   begin
      if (!nrst)
         req <= '0;
      else if (hready)
      begin
         req.valid <= take && rok;
         req.write <= hwrite;
         req.index <= haddr[17:2];
         req.lane <= haddr[1:0];
         req.byte_acc <= rbyte;
      end
   end

   assign wr = req.valid && req.write;
   assign commit = wr && (!req.byte_acc || req.lane == 2'h0);
   assign wr_hi = wr && req.byte_acc && req.lane == 2'h1;
   assign wv16 = req.byte_acc ? {temp, hwdata[7:0]} : hwdata[15:0]; // see RULE23
   assign wv8 = hwdata[7:0];
   assign wr_cnt = commit && req.index == `FTCU_IDX_CNT;
   assign flg_wr = commit && req.index == `FTCU_IDX_FLG;
   assign flg_rd = rd && ridx == `FTCU_IDX_FLG && (!rbyte || rlane == 2'h0);

   always_comb
   begin
      rtemp = 1'b0;
      case (ridx)
         `FTCU_IDX_IEN: rv = {8'h00, ien, 1'b1}; // see RULE18
         `FTCU_IDX_FLG: rv = {8'h00, flags, cclr};
         `FTCU_IDX_CNT:
         begin
            rv = cnt;
            rtemp = 1'b1;
         end
         `FTCU_IDX_CMP: rv = occ.compare_register_select ? cmp_b : cmp_a; // see RULE7
         `FTCU_IDX_CTL: rv = {8'h00, ctl};
         `FTCU_IDX_OCC: rv = {8'h00, occ};
         `FTCU_IDX_CAPA, `FTCU_IDX_CAPB, `FTCU_IDX_CAPC, `FTCU_IDX_CAPD:
         begin
            rv = capv[ridx[2:1]];
            rtemp = 1'b1;
         end
         default: rv = 16'h0000;
      endcase
      if (!rok)
      begin
         rv = 16'h0000;
         rtemp = 1'b0;
      end
   end

   // byte reads of low lane of count and capture come from the latch; word reads are whole anyway
   always_ff @(posedge clock)
   begin
      if (!nrst)
         hrdata <= 32'h00000000;
      else if (take && !hwrite)
         hrdata <= {16'h0000, rv[15:8], (rbyte && rlane == 2'h0 && rtemp) ? temp : rv[7:0]}; // see RULE15
   end

   // one latch shared by all wide registers, so interleaved pairs corrupt each other
   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
         temp <= 8'h00;
      else if (rd && rbyte && rlane == 2'h1 && rtemp)
         temp <= rv[7:0]; // see RULE4 RULE15 RULE23
      else if (wr_hi && (req.index == `FTCU_IDX_CNT || req.index == `FTCU_IDX_CMP))
         temp <= hwdata[15:8]; // see RULE4 RULE7
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
      begin
         ien <= 7'(`FTCU_RST_IEN >> 1); // see RULE18
         ctl <= ftcu_ctl_t'(`FTCU_RST_CTL);
         occ <= ftcu_occ_t'(`FTCU_RST_OCC);
         cclr <= 1'b0;
      end
      else if (commit)
      begin
         if (req.index == `FTCU_IDX_IEN)
            ien <= wv8[7:1];
         if (req.index == `FTCU_IDX_CTL)
            ctl <= ftcu_ctl_t'(wv8);
         if (req.index == `FTCU_IDX_OCC)
            occ <= ftcu_occ_t'({occ.fixed_ones, wv8[4:0]});
         if (req.index == `FTCU_IDX_FLG)
            cclr <= wv8[`FTCU_BIT_CCLR]; // see RULE22
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign match_a = cmp_a == cnt; // see RULE5
   assign match_b = cmp_b == cnt;
   assign wrap_ev = tick && !wr_cnt && cnt == 16'hffff && !(cclr && match_a); // see RULE2

   // software write beats a tick in the same cycle
   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
         cnt <= `FTCU_RST_CNT; // see RULE3
      else if (wr_cnt)
         cnt <= wv16; // see RULE4
      else if (tick)
         cnt <= (cclr && match_a) ? `FTCU_RST_CNT : cnt + 16'h0001; // see RULE1 RULE3 RULE22
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
      begin
         cmp_a <= `FTCU_RST_CMP; // see RULE8
         cmp_b <= `FTCU_RST_CMP;
      end
      else if (commit && req.index == `FTCU_IDX_CMP)
      begin
         if (occ.compare_register_select) // see RULE7
            cmp_b <= wv16;
         else
            cmp_a <= wv16;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
      begin
         compare_pin_a <= 1'b0;
         compare_pin_b <= 1'b0;
      end
      else
      begin
         if (occ.output_enable_a && match_a)
            compare_pin_a <= occ.output_level_a; // see RULE6
         if (occ.output_enable_b && match_b)
            compare_pin_b <= occ.output_level_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pair p: primary p, buffer p+2 (a with c, b with d)
   for (genvar p = 0; p < 2; p++)
   begin : g_pair
      logic [CNT_W-1:0] prim;
      logic [CNT_W-1:0] buff;
      logic both;
      assign both = bufe[p] && (es[p] != es[p+2]); // see RULE13
      assign trig[p] = both ? (rise[p] || fall[p]) : (es[p] ? rise[p] : fall[p]); // see RULE14
      assign trig[p+2] = es[p+2] ? rise[p+2] : fall[p+2];
      always_ff @(posedge clock)
      begin
         if (!nrst || clr)
         begin
            prim <= `FTCU_RST_CAP; // see RULE17
            buff <= `FTCU_RST_CAP;
         end
         else
         begin
            if (trig[p])
               prim <= cnt; // see RULE9 RULE10
            if (bufe[p] && trig[p])
               buff <= prim; // see RULE11 RULE12
            else if (!bufe[p] && trig[p+2])
               buff <= cnt; // see RULE20
         end
      end
      assign capv[p] = prim;
      assign capv[p+2] = buff;
   end

   ////////////////////////////////////////////////////////////////////////////
   assign set_ev = {trig[0], trig[1], trig[2], trig[3], match_a, match_b, wrap_ev};

   // hardware set wins over a software clear in the same cycle
   always_comb
   begin
      next_flags = flags;
      if (flg_wr)
         next_flags = flags & ~(armed & ~wv8[7:1]); // see RULE21
      next_flags = next_flags | set_ev; // see RULE9 RULE20
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
         flags <= 7'(`FTCU_RST_FLG >> 1);
      else
         flags <= next_flags;
   end

   // a bit may be cleared only after it was seen set
   always_ff @(posedge clock)
   begin
      if (!nrst || clr)
         armed <= 7'h00;
      else if (flg_rd)
         armed <= flags; // see RULE21
      else if (flg_wr)
         armed <= 7'h00;
   end

   assign irq_request = flags & ien; // see RULE19

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   cnt_step_a: assert property (tick && !wr_cnt && !(cclr && match_a) && !clr
      |=> cnt == 16'($past(cnt) + 16'h0001)) else $error("counter did not step"); // see RULE1
   wrap_set_a: assert property (wrap_ev && !clr |=> flags[`FTCU_BIT_WRAP] && cnt == 16'h0000)
      else $error("overflow not flagged"); // see RULE2
   match_clear_a: assert property (tick && cclr && match_a && !wr_cnt && !clr
      |=> cnt == 16'h0000) else $error("match A did not clear count"); // see RULE3
   standby_init_a: assert property (clr |=> cnt == 16'h0000 && cmp_a == 16'hffff
      && cmp_b == 16'hffff && capv[3] == 16'h0000 && ien == 7'h00)
      else $error("standby did not initialise"); // see RULE8
   cmp_flag_a: assert property (match_b && !clr |=> flags[`FTCU_BIT_CMPB])
      else $error("compare B not flagged"); // see RULE5
   cmp_pin_a: assert property (occ.output_enable_a && match_a && !clr
      |=> compare_pin_a == $past(occ.output_level_a)) else $error("pin A level wrong"); // see RULE6
   cap_load_a: assert property (trig[0] && !clr
      |=> capv[0] == $past(cnt) && flags[`FTCU_BIT_CAPA]) else $error("capture A lost"); // see RULE9
   buf_shift_a: assert property (trig[1] && bufe[1] && !clr
      |=> capv[3] == $past(capv[1]) && capv[1] == $past(cnt)) else $error("B buffer wrong"); // see RULE12
   flag_hold_a: assert property (flags[`FTCU_BIT_CAPA] && !clr && !flg_wr
      |=> flags[`FTCU_BIT_CAPA]) else $error("flag dropped without clear"); // see RULE21
   ien_bit0_a: assert property (rd && ridx == `FTCU_IDX_IEN && !rbyte
      |=> hrdata[0] == 1'b1) else $error("enable bit zero not one"); // see RULE18

   buf_cap_c: cover property (trig[0] && bufe[0]);
   wrap_c: cover property (wrap_ev);
   pin_c: cover property (occ.output_enable_b && match_b);
   flag_clr_c: cover property (flags[`FTCU_BIT_CMPA] ##1 !flags[`FTCU_BIT_CMPA]);
endmodule
`default_nettype wire

// ==== ftcu_params.svh ====
`ifndef FTCU_PARAMS_SVH
`define FTCU_PARAMS_SVH
// register indices; byte address is four times the index
`define FTCU_IDX_IEN 16'hff90
`define FTCU_IDX_FLG 16'hff91
`define FTCU_IDX_CNT 16'hff92
`define FTCU_IDX_CMP 16'hff94
`define FTCU_IDX_CTL 16'hff96
`define FTCU_IDX_OCC 16'hff97
`define FTCU_IDX_CAPA 16'hff98
`define FTCU_IDX_CAPB 16'hff9a
`define FTCU_IDX_CAPC 16'hff9c
`define FTCU_IDX_CAPD 16'hff9e
// reset values
`define FTCU_RST_IEN 8'h01
`define FTCU_RST_FLG 8'h00
`define FTCU_RST_CNT 16'h0000
`define FTCU_RST_CMP 16'hffff
`define FTCU_RST_CAP 16'h0000
`define FTCU_RST_CTL 8'h00
`define FTCU_RST_OCC 8'he0
// flag and interrupt enable bit positions
`define FTCU_BIT_CAPA 7
`define FTCU_BIT_CAPB 6
`define FTCU_BIT_CAPC 5
`define FTCU_BIT_CAPD 4
`define FTCU_BIT_CMPA 3
`define FTCU_BIT_CMPB 2
`define FTCU_BIT_WRAP 1
`define FTCU_BIT_CCLR 0
// prescaler masks: tick when the low bits are all ones
`define FTCU_DIV2_MASK 5'h01
`define FTCU_DIV8_MASK 5'h07
`define FTCU_DIV32_MASK 5'h1f
`endif

// ==== ftcu_pkg.sv ====
`default_nettype none
package ftcu_pkg;
   typedef enum logic [1:0] {FTCU_CS_DIV2, FTCU_CS_DIV8, FTCU_CS_DIV32, FTCU_CS_EXT} ftcu_clksel_t;
   typedef struct packed {
      logic edge_select_a;
      logic edge_select_b;
      logic edge_select_c;
      logic edge_select_d;
      logic buffer_enable_a;
      logic buffer_enable_b;
      ftcu_clksel_t clock_select;
   } ftcu_ctl_t;
   typedef struct packed {
      logic [2:0] fixed_ones;
      logic compare_register_select;
      logic output_enable_a;
      logic output_enable_b;
      logic output_level_a;
      logic output_level_b;
   } ftcu_occ_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] index;
      logic [1:0] lane;
      logic byte_acc;
   } ftcu_req_t;
endpackage
`default_nettype wire

// ==== ftcu_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module ftcu_sync
(
   input wire logic clock, // system clock
   input wire logic nrst, // sync reset, low
   input wire logic pin, // raw pin
   output logic rise, // one-cycle pulse
   output logic fall // one-cycle pulse
);
   logic s1;
   logic s2;
   logic s3;
   logic level;

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end
      else
      begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clock)
   begin
      if (!nrst)
         level <= 1'b0;
      else if (s2 == s3)
         level <= s3;
   end

   assign rise = (s2 == s3) && s3 && !level;
   assign fall = (s2 == s3) && !s3 && level;
endmodule
`default_nettype wire

// ==== ftcu_presc.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ftcu_params.svh"
module ftcu_presc
   import ftcu_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic nrst, // sync reset, low
   input wire logic clear, // standby clear
   input wire ftcu_clksel_t clock_select, // source
   input wire logic ext_rise, // external edge pulse
   output logic tick // count pulse
);
   logic [4:0] div;

   always_ff @(posedge clock)
   begin
      if (!nrst || clear)
         div <= 5'h00;
      else
         div <= div + 5'h01;
   end

   always_comb
   begin
      case (clock_select)
         FTCU_CS_DIV2: tick = (div & `FTCU_DIV2_MASK) == `FTCU_DIV2_MASK;
         FTCU_CS_DIV8: tick = (div & `FTCU_DIV8_MASK) == `FTCU_DIV8_MASK;
         FTCU_CS_DIV32: tick = div == `FTCU_DIV32_MASK;
         FTCU_CS_EXT: tick = ext_rise;
         default: tick = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ==== ftcu_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// stands in for the outside world driving the capture pins and the count clock
module ftcu_pin_model
(
   input wire logic clock, // system clock
   input wire logic nrst, // sync reset, low
   input wire logic [4:0] want, // requested levels, bit4 count clock
   output logic [4:0] pins // levels on the wires
);
   logic [1:0] hold [5];

   // a level stands at least four clocks, above the both-edge minimum width
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < 5; i++)
      begin
         if (!nrst)
         begin
            pins[i] <= 1'b0;
            hold[i] <= 2'd0;
         end
         else if (hold[i] != 2'd0)
         begin
            hold[i] <= hold[i] - 2'd1;
         end
         else if (pins[i] != want[i])
         begin
            pins[i] <= want[i];
            hold[i] <= 2'd3;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ftcu_params.svh"
module tb_top;
   localparam logic [31:0] A_IEN = {14'h0, `FTCU_IDX_IEN, 2'b00};
   localparam logic [31:0] A_FLG = {14'h0, `FTCU_IDX_FLG, 2'b00};
   localparam logic [31:0] A_CNT = {14'h0, `FTCU_IDX_CNT, 2'b00};
   localparam logic [31:0] A_CMP = {14'h0, `FTCU_IDX_CMP, 2'b00};
   localparam logic [31:0] A_CTL = {14'h0, `FTCU_IDX_CTL, 2'b00};
   localparam logic [31:0] A_OCC = {14'h0, `FTCU_IDX_OCC, 2'b00};
   localparam logic [31:0] A_CAPA = {14'h0, `FTCU_IDX_CAPA, 2'b00};
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic standby = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [4:0] want = 5'h00;
   logic [31:0] rd;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic [4:0] pins;
   wire logic cmp_a;
   wire logic cmp_b;
   wire logic [6:0] irq;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;

   ftcu_timer u_dut (.clock(clock), .nrst(nrst), .standby(standby), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .capture_pin_a(pins[0]), .capture_pin_b(pins[1]), .capture_pin_c(pins[2]),
      .capture_pin_d(pins[3]), .external_count_clock(pins[4]),
      .compare_pin_a(cmp_a), .compare_pin_b(cmp_b), .irq_request(irq));

   ftcu_pin_model u_pins (.clock(clock), .nrst(nrst), .want(want), .pins(pins));

   always #10 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   // entered just after a rising edge; hready is the slave's own hreadyout
   task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
                       input logic [31:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, 3'h2, d, rd);
   endtask

   task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 3'h2, 32'h0, r);
      chk(n, e, r);
   endtask

   // room for pin hold, three-flop sync and the capture edge
   task automatic pin(input int i, input logic v);
      want[i] <= v;
      repeat (10) @(posedge clock);
   endtask

   task automatic tick(input int n);
      repeat (n)
      begin
         pin(4, 1'b1);
         pin(4, 1'b0);
      end
   endtask

   function automatic logic [31:0] cap(input int i);
      return A_CAPA + 32'(i * 8);
   endfunction

   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         fail_count++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      rdc("interrupt_enable", A_IEN, 32'h01);
      rdc("event_flag_reg", A_FLG, 32'h00);
      rdc("compare_value_a", A_CMP, 32'hffff);
      rdc("timer_control", A_CTL, 32'h00);
      rdc("compare_output_control", A_OCC, 32'he0);
      for (int i = 0; i < 4; i++)
         rdc("capture_value", cap(i), 32'h0);
      wr(A_OCC, 32'h10);
      rdc("compare_value_b", A_CMP, 32'hffff);
      wr(32'h0004_0000, 32'h5a);
      rdc("unmapped", 32'h0004_0000, 32'h0);
      wr(A_IEN, 32'h00);
      rdc("interrupt_enable", A_IEN, 32'h01);
      wr(A_IEN, 32'hfe);
      rdc("interrupt_enable", A_IEN, 32'hff);
      // external count source keeps the counter still between pulses
      wr(A_CTL, 32'h03);
      wr(A_CNT, 32'h1234);
      rdc("free_count", A_CNT, 32'h1234);
      xfer(1'b1, A_CNT + 32'h1, 3'h0, 32'h0000ab00, rd);
      rdc("free_count", A_CNT, 32'h1234);
      xfer(1'b1, A_CNT, 3'h0, 32'h000000cd, rd);
      rdc("free_count", A_CNT, 32'habcd);
      tick(3);
      rdc("free_count", A_CNT, 32'habd0);
      wr(A_CNT, 32'hffff);
      tick(1);
      wr(A_FLG, 32'h00);
      rdc("free_count", A_CNT, 32'h0000);
      chk("irq_request", 32'h07, {25'h0, irq});
      rdc("event_flag_reg", A_FLG, 32'h0e);
      wr(A_FLG, 32'h00);
      rdc("event_flag_reg", A_FLG, 32'h00);
      chk("irq_request", 32'h00, {25'h0, irq});
      wr(A_FLG, 32'hfe);
      rdc("event_flag_reg", A_FLG, 32'h00);
      // compare channels share one address
      wr(A_OCC, 32'h0f);
      wr(A_CMP, 32'h0005);
      wr(A_OCC, 32'h1f);
      wr(A_CMP, 32'h0007);
      rdc("compare_value_b", A_CMP, 32'h0007);
      wr(A_OCC, 32'h0f);
      rdc("compare_value_a", A_CMP, 32'h0005);
      chk("compare_pin_a", 32'h0, {31'h0, cmp_a});
      wr(A_CNT, 32'h0004);
      tick(1);
      chk("compare_pin_a", 32'h1, {31'h0, cmp_a});
      chk("compare_pin_b", 32'h0, {31'h0, cmp_b});
      rdc("event_flag_reg", A_FLG, 32'h08);
      tick(2);
      chk("compare_pin_b", 32'h1, {31'h0, cmp_b});
      rdc("event_flag_reg", A_FLG, 32'h0c);
      wr(A_FLG, 32'h01);
      wr(A_CNT, 32'h0005);
      tick(1);
      rdc("free_count", A_CNT, 32'h0000);
      rdc("event_flag_reg", A_FLG, 32'h0d);
      wr(A_FLG, 32'h00);
      // unbuffered, rising edges
      wr(A_CTL, 32'hf3);
      for (int i = 0; i < 4; i++)
      begin
         wr(A_CNT, 32'h1000 + 32'(i));
         pin(i, 1'b1);
         rdc("capture_value", cap(i), 32'h1000 + 32'(i));
      end
      rdc("event_flag_reg", A_FLG, 32'hf0);
      chk("irq_request", 32'h78, {25'h0, irq});
      wr(A_CNT, 32'h2222);
      pin(0, 1'b0);
      rdc("capture_value_a", A_CAPA, 32'h1000);
      pin(0, 1'b1);
      rdc("capture_value_a", A_CAPA, 32'h2222);
      // unbuffered, falling edges
      wr(A_CTL, 32'h03);
      for (int i = 0; i < 4; i++)
      begin
         wr(A_CNT, 32'h3344 + 32'(i));
         pin(i, 1'b0);
         rdc("capture_value", cap(i), 32'h3344 + 32'(i));
      end
      xfer(1'b0, A_CAPA + 32'h1, 3'h0, 32'h0, rd);
      chk("capture high byte", 32'h33, {24'h0, rd[15:8]});
      xfer(1'b0, A_CAPA, 3'h0, 32'h0, rd);
      chk("capture low byte", 32'h44, {24'h0, rd[7:0]});
      // both buffers, like edge bits: rising only
      wr(A_CTL, 32'hff);
      wr(A_CNT, 32'h5555);
      pin(0, 1'b1);
      rdc("capture_value_a", A_CAPA, 32'h5555);
      rdc("capture_value_c", cap(2), 32'h3344);
      pin(1, 1'b1);
      rdc("capture_value_b", cap(1), 32'h5555);
      rdc("capture_value_d", cap(3), 32'h3345);
      wr(A_CNT, 32'h6666);
      pin(0, 1'b0);
      rdc("capture_value_a", A_CAPA, 32'h5555);
      // unlike edge bits on a/c: both edges on a, only a rising edge driven; c's falling edge only flags
      wr(A_CTL, 32'hdf);
      pin(0, 1'b1);
      rdc("capture_value_a", A_CAPA, 32'h6666);
      rdc("capture_value_c", cap(2), 32'h5555);
      rdc("event_flag_reg", A_FLG, 32'hf0);
      wr(A_FLG, 32'h00);
      pin(2, 1'b1);
      pin(2, 1'b0);
      rdc("event_flag_reg", A_FLG, 32'h20);
      rdc("capture_value_c", cap(2), 32'h5555);
      standby <= 1'b1;
      repeat (3) @(posedge clock);
      standby <= 1'b0;
      @(posedge clock);
      rdc("interrupt_enable", A_IEN, 32'h01);
      rdc("compare_value_a", A_CMP, 32'hffff);
      rdc("capture_value_a", A_CAPA, 32'h0);
      rdc("event_flag_reg", A_FLG, 32'h00);
      chk("hresp", 32'h0, {31'h0, hresp});
      // internal sources: ten pulses of each divider between two samples
      for (int s = 0; s < 3; s++)
      begin
         wr(A_CTL, 32'(s));
         xfer(1'b0, A_CNT, 3'h2, 32'h0, rd);
         repeat ((2 << (2 * s)) * 10 - 2) @(posedge clock);
         rdc("free_count", A_CNT, rd + 32'h0000000a);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
